// file: design/pld_params.svh
// Timing and sizing constants for the PLL digital lock detector
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// Comparison window as a time, and the core clock period, both in ps
`define PLD_WINDOW_PS      3700
`define PLD_CLK_PERIOD_PS  4000
// Longest time rounds down, but never below one cycle
`define PLD_WINDOW_CYC_RAW (`PLD_WINDOW_PS / `PLD_CLK_PERIOD_PS)
`define PLD_WINDOW_CYC     ((`PLD_WINDOW_CYC_RAW < 1) ? 1 : `PLD_WINDOW_CYC_RAW)
// Scale factor of the accuracy figure, in ppm
`define PLD_PPM_SCALE      2000000
// Width of the window wait counter
`define PLD_WAIT_W         4
// Reset values
`define PLD_COUNT_RST      0
`define PLD_LOCK_RST       1'b0

`endif

// file: design/pld_pkg.sv
// Types and helper functions shared by the lock detector files
package pld_pkg;

    // Pairing state of one phase detector comparison
    typedef enum logic [2:0] {
        PLD_IDLE     = 3'b001,
        PLD_WAIT_FB  = 3'b010,
        PLD_WAIT_REF = 3'b100
    } pld_state_e;

    // Implied accuracy in milli-ppm: 2e6 * 3.7 ns * fpd / target [R7]
    function automatic longint pld_ppm_milli(input longint fpd_hz, input longint target);
        longint num;
        num = (longint'(2) * fpd_hz * 37) / 10;   // 2e6 * 3.7e-9 * 1000 = 7.4
        pld_ppm_milli = (target == 0) ? 0 : num / target;
    endfunction : pld_ppm_milli

endpackage : pld_pkg

// file: design/pld_edge_if.sv
// Edge event carrier between the pin synchroniser and the lock detector
`timescale 1ns/1ps
interface pld_edge_if;
    logic ref_rise;   // Divided reference rising edge, one-cycle pulse
    logic fb_rise;    // Divided feedback rising edge, one-cycle pulse

    modport src (output ref_rise, output fb_rise);
    modport dst (input  ref_rise, input  fb_rise);
endinterface : pld_edge_if

// file: design/pld_edge_sync.sv
// Three-stage synchroniser and rising-edge detector for the divider outputs
`timescale 1ns/1ps
module pld_edge_sync (
    input  wire logic clk_i,      // Core clock
    input  wire logic reset_n_i,  // Asynchronous reset, active low
    input  wire logic ref_div_i,  // Divided reference from its pin
    input  wire logic fb_div_i,   // Divided feedback from its pin
    pld_edge_if.src   edge_o      // Edge pulses to the detector
);

    logic [1:0] raw;
    logic [1:0] rise;

    assign raw = {fb_div_i, ref_div_i};

    ////////////////////////////////////////////////////////////////////////////
    // One channel per divider output
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            logic s1_reg, s2_reg, s3_reg, lvl_reg;
            logic lvl_next;

            // A change is accepted only once stages two and three agree
            always_comb begin
                lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
            end

            // Stage one feeds stage two only, never any logic
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg  <= raw[g];
                    s2_reg  <= s1_reg;
                    s3_reg  <= s2_reg;
                    lvl_reg <= lvl_next;
                end
            end

            assign rise[g] = lvl_next & ~lvl_reg;
        end
    endgenerate

    // Both channels see the same latency, so their spacing is preserved
    assign edge_o.ref_rise = rise[0];
    assign edge_o.fb_rise  = rise[1];

endmodule : pld_edge_sync

// file: design/pld_lock_detect.sv
// Digital lock detector: window compare, in-window counter and lock flag
// What this block does
// [R1] Pair ref and feedback edges within 3.7 ns; the code pairs edges up to one 4 ns clock apart
// [R2] Each in-window cycle below target adds one to count
// [R3] Any out-of-window cycle clears count to zero
// [R4] Lock only once count reaches the target
// [R5] Target comes from a software-programmed value
// [R6] Lock no sooner than target comparison cycles
// [R7] Accuracy equals 2e6 times window times fpd/target
// [R8] Lock drops on a miss, returns at target
`timescale 1ns/1ps
`include "pld_params.svh"
module pld_lock_detect #(
    parameter int CNT_W = 16              // Width of lock count and target
) (
    input  wire logic             clk_i,               // Core clock, 250 MHz
    input  wire logic             reset_n_i,           // Asynchronous reset, active low
    input  wire logic             ref_div_i,           // Divided reference pin
    input  wire logic             fb_div_i,            // Divided feedback pin
    input  wire logic [CNT_W-1:0] lock_count_target_i, // Programmed lock count
    output logic                  lock_o,              // Lock detected, level
    output logic [CNT_W-1:0]      lock_count_o,        // Running in-window count
    output logic                  window_hit_o,        // In-window cycle, pulse
    output logic                  window_miss_o        // Out-of-window cycle, pulse
);

    // Window length in clocks less one; the wait counter stops there
    localparam logic [`PLD_WAIT_W-1:0] WIN_M1 = `PLD_WAIT_W'(`PLD_WINDOW_CYC - 1);
    localparam logic [CNT_W-1:0]       CNT_RST = CNT_W'(`PLD_COUNT_RST);
    localparam logic [CNT_W-1:0]       CNT_ONE = CNT_W'(1);

    pld_edge_if edges ();

    // Pairing, counter and lock state with their next values
    pld_pkg::pld_state_e    state_reg, state_next;
    logic [`PLD_WAIT_W-1:0] wait_reg,  wait_next;
    logic [CNT_W-1:0]       count_reg, count_next;
    logic                   lock_reg,  lock_next;
    logic                   hit_reg,   miss_reg;
    logic                   hit, miss;
    logic                   ref_e, fb_e;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the two paths share latency so the skew survives
    pld_edge_sync pld_edge_sync_inst (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ref_div_i (ref_div_i),
        .fb_div_i  (fb_div_i),
        .edge_o    (edges.src)
    );

    assign ref_e = edges.ref_rise;
    assign fb_e  = edges.fb_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Edge pairing: the first edge opens the window, the other must follow
    // Window resolution is one clock; sub-cycle error cannot be seen here
    always_comb begin
        state_next = state_reg;
        wait_next  = wait_reg;
        hit        = 1'b0;
        miss       = 1'b0;
        case (state_reg)
            pld_pkg::PLD_IDLE: begin
                if (ref_e && fb_e) begin
                    hit = 1'b1;                                  // [R1]
                end else if (ref_e) begin
                    state_next = pld_pkg::PLD_WAIT_FB;
                    wait_next  = '0;
                end else if (fb_e) begin
                    state_next = pld_pkg::PLD_WAIT_REF;
                    wait_next  = '0;
                end
            end
            pld_pkg::PLD_WAIT_FB: begin
                if (fb_e) begin
                    hit        = 1'b1;                           // [R1]
                    state_next = pld_pkg::PLD_IDLE;
                end else if (ref_e) begin
                    miss      = 1'b1;                            // [R1]
                    wait_next = '0;
                end else if (wait_reg == WIN_M1) begin
                    miss       = 1'b1;                           // [R1]
                    state_next = pld_pkg::PLD_IDLE;
                end else begin
                    wait_next = wait_reg + 1'b1;
                end
            end
            pld_pkg::PLD_WAIT_REF: begin
                if (ref_e) begin
                    hit        = 1'b1;                           // [R1]
                    state_next = pld_pkg::PLD_IDLE;
                end else if (fb_e) begin
                    miss      = 1'b1;                            // [R1]
                    wait_next = '0;
                end else if (wait_reg == WIN_M1) begin
                    miss       = 1'b1;                           // [R1]
                    state_next = pld_pkg::PLD_IDLE;
                end else begin
                    wait_next = wait_reg + 1'b1;
                end
            end
            default: begin
                state_next = pld_pkg::PLD_IDLE;
                wait_next  = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock counter; saturates at target so it cannot wrap back below it
    always_comb begin
        count_next = count_reg;
        if (miss) begin
            count_next = CNT_RST;                                // [R3]
        end else if (hit && (count_reg < lock_count_target_i)) begin
            count_next = count_reg + CNT_ONE;                    // [R2]
        end
        // Target zero never locks, so an unprogrammed detector stays quiet
        lock_next = (lock_count_target_i != CNT_RST) &&
                    (count_next >= lock_count_target_i);         // [R4] [R5] [R6] [R8]
    end

    // State registers and the hit and miss output pulse registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= pld_pkg::PLD_IDLE;
            wait_reg  <= '0;
            count_reg <= CNT_RST;
            lock_reg  <= `PLD_LOCK_RST;
            hit_reg   <= 1'b0;
            miss_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
            count_reg <= count_next;
            lock_reg  <= lock_next;
            hit_reg   <= hit;
            miss_reg  <= miss;
        end
    end

    assign lock_o        = lock_reg;
    assign lock_count_o  = count_reg;
    assign window_hit_o  = hit_reg;
    assign window_miss_o = miss_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_same_cycle_hit: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (state_reg == pld_pkg::PLD_IDLE && ref_e && fb_e) |=> window_hit_o)
        else $error("coincident edges not counted as in-window");

    // Pairing outcomes, in both orders of arrival
    a_fb_timeout: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (state_reg == pld_pkg::PLD_WAIT_FB && wait_reg == WIN_M1 && !fb_e)
        |=> (window_miss_o && count_reg == CNT_RST))
        else $error("late feedback edge did not end as a miss");

    a_ref_timeout: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (state_reg == pld_pkg::PLD_WAIT_REF && wait_reg == WIN_M1 && !ref_e)
        |=> (window_miss_o && count_reg == CNT_RST))
        else $error("late reference edge did not end as a miss");

    a_fb_late_hit: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (state_reg == pld_pkg::PLD_WAIT_FB && fb_e) |=> window_hit_o)
        else $error("feedback edge inside window not counted");

    a_ref_late_hit: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (state_reg == pld_pkg::PLD_WAIT_REF && ref_e) |=> window_hit_o)
        else $error("reference edge inside window not counted");

    a_hit_increments: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
        (hit && !miss && count_reg < lock_count_target_i && $stable(lock_count_target_i))
        |=> count_reg == $past(count_reg) + CNT_ONE)
        else $error("in-window cycle did not add one to count");

    a_miss_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        miss |=> (count_reg == CNT_RST) && window_miss_o)
        else $error("out-of-window cycle did not clear count");

    a_lock_needs_count: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R4]
        lock_o |-> (count_reg >= $past(lock_count_target_i)) && !window_miss_o)
        else $error("lock shown below target count");

    // A target change alone may move lock either way, so such cycles are excused
    a_lock_rise_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R6]
        ($rose(lock_o) && $past(lock_count_target_i) == $past(lock_count_target_i, 2))
        |-> $past(hit))
        else $error("lock rose without an in-window cycle");

    a_lock_drops_miss: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
        window_miss_o |-> !lock_o)
        else $error("lock held through a miss");

    a_lock_at_target: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
        (hit && !miss && lock_count_target_i != CNT_RST &&
         count_reg + CNT_ONE == lock_count_target_i) ##1 $stable(lock_count_target_i)
        |-> lock_o)
        else $error("lock not raised when count reached target");

    // Counter and lock outcomes
    a_lock_falls_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
        $fell(lock_o) |-> window_miss_o ||
        ($past(lock_count_target_i) != $past(lock_count_target_i, 2)))
        else $error("lock fell without a miss or target change");

    a_lock_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
        (lock_o && !miss && lock_count_target_i == $past(lock_count_target_i))
        |=> lock_o)
        else $error("lock dropped without a miss");

    a_zero_no_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
        (lock_count_target_i == CNT_RST) |=> !lock_o)
        else $error("lock shown with a zero target");

    a_count_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
        (!window_hit_o && !window_miss_o) |-> $stable(lock_count_o))
        else $error("count moved without a comparison");

    a_count_saturates: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R4]
        (lock_count_target_i == $past(lock_count_target_i) &&
         $past(lock_count_o) <= lock_count_target_i) |-> lock_count_o <= lock_count_target_i)
        else $error("count passed the target");

endmodule : pld_lock_detect

// file: verification/pld_div_model.sv
// Partner model: divided reference and feedback outputs with a set skew
`timescale 1ns/1ps
module pld_div_model #(
    parameter int PERIOD = 8,  // Comparison period in core clocks
    parameter int HIGH   = 4   // High time of each divided output
) (
    input  wire logic       clk_i,      // Core clock
    input  wire logic       reset_n_i,  // Asynchronous reset, active low
    input  wire logic       run_i,      // Dividers running
    input  wire logic [3:0] skew_i,     // Feedback delay after reference
    output logic            ref_div_o,  // Divided reference
    output logic            fb_div_o    // Divided feedback
);
    int phase_reg;
    int fb_phase;
    ////////////////////////////////////////////////////////////////////////////
    // Skew between half a period and a whole period wraps round, so the feedback then leads
    always_comb fb_phase = (phase_reg - int'(skew_i) + PERIOD) % PERIOD;
    // Stopped dividers sit low, so no stray edge reaches the detector
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_reg <= 0;
            ref_div_o <= 1'b0;
            fb_div_o  <= 1'b0;
        end else begin
            phase_reg <= run_i ? (phase_reg + 1) % PERIOD : 0;
            ref_div_o <= run_i && (phase_reg < HIGH);
            fb_div_o  <= run_i && (fb_phase < HIGH);
        end
    end
endmodule : pld_div_model

// file: verification/pld_lock_detect_bench.sv
// Self-checking bench for the PLL digital lock detector
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pld_lock_detect_bench;
    logic        clk_i;
    logic        reset_n_i;
    logic        run;
    logic [3:0]  skew;
    logic        ref_div, fb_div, lock_o, hit, miss;
    logic [15:0] target, count;
    int          n_mismatch, check_count, cycles;
    ////////////////////////////////////////////////////////////////////////////
    pld_div_model pld_div_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run),
        .skew_i(skew), .ref_div_o(ref_div), .fb_div_o(fb_div));
    pld_lock_detect pld_lock_detect_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .ref_div_i(ref_div), .fb_div_i(fb_div), .lock_count_target_i(target),
        .lock_o(lock_o), .lock_count_o(count), .window_hit_o(hit), .window_miss_o(miss));
    ////////////////////////////////////////////////////////////////////////////
    // Clock at 250 MHz
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // Counts hits since the last miss until lock, checking the count on each hit
    task automatic wait_lock(input int t);
        int hits;
        hits = 0;
        while (lock_o !== 1'b1) begin
            @(posedge clk_i);
            #1;
            if (miss === 1'b1) hits = 0;
            if (hit === 1'b1) begin
                hits++;
                `CHK(count, 16'(hits))
            end
        end
        `CHK(hits, t)
        `CHK(count, target)
    endtask : wait_lock
    // Lock from reset after exactly target in-window cycles
    task automatic lock_test();
        @(posedge clk_i);
        target <= 16'h0004;
        skew   <= 4'h0;
        run    <= 1'b1;
        wait_lock(4);
        $display("test lock_test done");
    endtask : lock_test
    // A late feedback edge clears count and drops lock; lock returns at target
    task automatic miss_test();
        int n;
        @(posedge clk_i);
        skew <= 4'h3;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (miss !== 1'b1 && n < 40);
        `CHK(miss, 1'b1)
        `CHK(count, 16'h0000)
        `CHK(lock_o, 1'b0)
        @(posedge clk_i);
        target <= 16'h0005;
        skew   <= 4'h1;
        wait_lock(5);
        $display("test miss_test done");
    endtask : miss_test
    // Window edge in both orders: one clock apart hits, two clocks misses
    task automatic window_test();
        logic [3:0] skews [5] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7};
        logic       exp   [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        int n;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i);
            skew <= skews[i];
            repeat (20) @(posedge clk_i);
            n = 0;
            do begin
                @(posedge clk_i);
                #1;
                n++;
            end while (hit !== 1'b1 && miss !== 1'b1 && n < 20);
            `CHK(hit, exp[i])
            `CHK(miss, ~exp[i])
        end
        $display("test window_test done");
    endtask : window_test
    // Target zero never locks however many hits arrive
    task automatic zero_test();
        logic seen;
        seen = 1'b0;
        @(posedge clk_i);
        target <= 16'h0000;
        skew   <= 4'h0;
        repeat (80) begin
            @(posedge clk_i);
            #1;
            if (lock_o !== 1'b0) seen = 1'b1;
        end
        `CHK(seen, 1'b0)
        $display("test zero_test done");
    endtask : zero_test
    // Accuracy figure: 40 MHz comparisons with target 10000 give 29.6 ppm
    task automatic accuracy_test();
        `CHK(pld_pkg::pld_ppm_milli(64'd40000000, 64'd10000), 64'd29600)
        $display("test accuracy_test done");
    endtask : accuracy_test
    // Main sequence: two-cycle reset, then each scenario
    initial begin
        reset_n_i   = 1'b0;
        run         = 1'b0;
        skew        = 4'h0;
        target      = 16'h0004;
        n_mismatch  = 0;
        check_count = 0;
        cycles      = 0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHK(lock_o, 1'b0)
        `CHK(count, 16'h0000)
        lock_test();
        miss_test();
        window_test();
        zero_test();
        accuracy_test();
        final_report();
    end
endmodule : pld_lock_detect_bench
